// [rtl/rdmh_regs.svh]
// Register offsets, fields, reset values and rates.
// Assumes byte addresses on an 8-bit register address, 32-bit data.
`ifndef RDMH_REGS_SVH
`define RDMH_REGS_SVH

`define RDMH_AW        8
`define RDMH_CFG       8'h00
`define RDMH_CTRL      8'h04
`define RDMH_TXDATA    8'h08
`define RDMH_RXDATA    8'h0C
`define RDMH_ERR       8'h10
`define RDMH_ISTAT     8'h14
`define RDMH_IMASK     8'h18
`define RDMH_LINE      8'h1C

`define RDMH_CFG_W     15
`define RDMH_CFG_RST   15'h0508
`define RDMH_CTRL_RST  1'h1
`define RDMH_ERR_W     7
`define RDMH_ERR_FRONT 3
`define RDMH_ERR_OVR   4
`define RDMH_ERR_PAR   5
`define RDMH_ERR_FRM   6
`define RDMH_INT_RX    0
`define RDMH_INT_TX    1
`define RDMH_INT_ERR   2

`define RDMH_CLK_HZ    50000000
`define RDMH_NBAUD     9
`define RDMH_NSEL      7
`define RDMH_CH_XON    8'h11
`define RDMH_CH_XOFF   8'h13

`endif

// [rtl/rdmh_pkg.sv]
// Types of the serial port modules.
// Assumes the register header for widths only.
package rdmh_pkg;

    typedef enum logic [2:0] {
        RDMH_PAR_NONE  = 3'h0,
        RDMH_PAR_EVEN  = 3'h1,
        RDMH_PAR_ODD   = 3'h2,
        RDMH_PAR_MARK  = 3'h3,
        RDMH_PAR_SPACE = 3'h4
    } rdmh_par_t;

    typedef enum logic [1:0] {
        RDMH_SW_NONE   = 2'h0,
        RDMH_SW_ENQACK = 2'h1,
        RDMH_SW_XONOFF = 2'h2
    } rdmh_sw_t;

    // Character frame layout
    typedef struct packed {
        logic      len8;
        logic      stop2;
        rdmh_par_t par;
    } rdmh_frame_t;

    // Configuration word, LSB is the rate index
    typedef struct packed {
        logic        lockout;
        logic        echo;
        rdmh_sw_t    swfc;
        logic        full_dup;
        logic        hs_on;
        rdmh_frame_t frm;
        logic [3:0]  baud;
    } rdmh_cfg_t;

    // Modem-side inputs
    typedef struct packed {
        logic cts;
        logic dsr;
        logic dcd;
    } rdmh_modem_t;

    // Parity bit under the frame setting
    function automatic logic rdmh_parity(logic [7:0] d, rdmh_frame_t f);
        logic x;
        x = f.len8 ? ^d : ^d[6:0];
        case (f.par)
            RDMH_PAR_EVEN:  rdmh_parity = x;
            RDMH_PAR_ODD:   rdmh_parity = ~x;
            RDMH_PAR_MARK:  rdmh_parity = 1'b1;
            default:        rdmh_parity = 1'b0;
        endcase
    endfunction

endpackage

// [rtl/rdmh_tx.sv]
// Transmitter: start, 7/8 data LSB first, parity, 1/2 stops.
// Assumes go is a one-cycle request taken only while busy is low.
`timescale 1ns/10ps
module rdmh_tx (
    input  wire logic                clk,     // System clock
    input  wire logic                ce,      // Clock enable
    input  wire logic                sys_rst, // Sync reset
    input  wire logic [23:0]         div,     // Cycles per bit
    input  wire rdmh_pkg::rdmh_frame_t frm,   // Frame format
    input  wire logic                go,      // Start a character
    input  wire logic [7:0]          data,    // Character
    output logic                     txd,     // Serial out, idle high
    output logic                     busy     // Character in flight
);
    import rdmh_pkg::*;

    typedef enum logic [2:0] {
        T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h3,
        T_PAR  = 3'h2, T_STOP  = 3'h6
    } rdmh_tst_t;

    typedef struct packed {
        rdmh_tst_t   st;
        logic [23:0] cnt;
        logic [2:0]  bitn;
        logic [7:0]  sh;
        logic [7:0]  dat;
        logic        stopn;
        logic        txd;
    } rdmh_txs_t;

    rdmh_txs_t s;
    rdmh_txs_t next_s;

    // One bit time per state step
    always_comb begin
        next_s = s;
        if (s.st != T_IDLE && s.cnt != div - 24'h1) begin
            next_s.cnt = s.cnt + 24'h1;
        end else begin
            next_s.cnt = 24'h0;
            case (s.st)
                T_IDLE: begin
                    if (go) begin
                        next_s.st  = T_START;
                        next_s.sh  = data;
                        next_s.dat = data;
                        next_s.txd = 1'b0;
                    end
                end
                T_START: begin
                    next_s.st   = T_DATA;
                    next_s.bitn = 3'h0;
                    next_s.txd  = s.sh[0];
                end
                T_DATA: begin
                    if (s.bitn == (frm.len8 ? 3'h7 : 3'h6)) begin
                        if (frm.par != RDMH_PAR_NONE) begin
                            next_s.st  = T_PAR;
                            next_s.txd = rdmh_parity(s.dat, frm);
                        end else begin
                            next_s.st    = T_STOP;
                            next_s.txd   = 1'b1;
                            next_s.stopn = frm.stop2;
                        end
                    end else begin
                        next_s.bitn = s.bitn + 3'h1;
                        next_s.sh   = {1'b0, s.sh[7:1]};
                        next_s.txd  = s.sh[1];
                    end
                end
                T_PAR: begin
                    next_s.st    = T_STOP;
                    next_s.txd   = 1'b1;
                    next_s.stopn = frm.stop2;
                end
                T_STOP: begin
                    if (s.stopn) begin
                        next_s.stopn = 1'b0;
                    end else begin
                        next_s.st = T_IDLE;
                    end
                end
                default: begin
                    next_s.st  = T_IDLE;
                    next_s.txd = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s     <= '0;
            s.txd <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign txd  = s.txd;
    assign busy = (s.st != T_IDLE);
endmodule

// [rtl/rdmh_rx.sv]
// Receiver sampling mid-bit; checks parity and first stop.
// Assumes rxd is already synchronous to clk.
`timescale 1ns/10ps
module rdmh_rx (
    input  wire logic                clk,     // System clock
    input  wire logic                ce,      // Clock enable
    input  wire logic                sys_rst, // Sync reset
    input  wire logic [23:0]         div,     // Cycles per bit
    input  wire rdmh_pkg::rdmh_frame_t frm,   // Frame format
    input  wire logic                rxd,     // Serial in
    output logic                     valid,   // Character done, pulse
    output logic [7:0]               data,    // Character
    output logic                     perr,    // Parity bad
    output logic                     ferr     // Stop bit low
);
    import rdmh_pkg::*;

    typedef enum logic [2:0] {
        R_IDLE = 3'h0, R_START = 3'h1, R_DATA = 3'h3,
        R_PAR  = 3'h2, R_STOP  = 3'h6
    } rdmh_rst_t;

    typedef struct packed {
        rdmh_rst_t   st;
        logic [23:0] cnt;
        logic [2:0]  bitn;
        logic [7:0]  sh;
        logic        valid;
        logic [7:0]  data;
        logic        perr;
        logic        ferr;
    } rdmh_rxs_t;

    rdmh_rxs_t s;
    rdmh_rxs_t next_s;
    logic [7:0] word;

    // Seven-bit characters land in the top of the shifter
    assign word = frm.len8 ? s.sh : {1'b0, s.sh[7:1]};

    // Half bit to start centre, then whole bits
    always_comb begin
        next_s       = s;
        next_s.valid = 1'b0;
        if (s.st == R_IDLE) begin
            if (!rxd) begin
                next_s.st  = R_START;
                next_s.cnt = {1'b0, div[23:1]};
            end
        end else if (s.cnt != 24'h0) begin
            next_s.cnt = s.cnt - 24'h1;
        end else begin
            next_s.cnt = div - 24'h1;
            case (s.st)
                R_START: begin
                    // A short low pulse is noise, not a start
                    next_s.st   = rxd ? R_IDLE : R_DATA;
                    next_s.bitn = 3'h0;
                    next_s.perr = 1'b0;
                end
                R_DATA: begin
                    next_s.sh   = {rxd, s.sh[7:1]};
                    next_s.bitn = s.bitn + 3'h1;
                    if (s.bitn == (frm.len8 ? 3'h7 : 3'h6)) begin
                        next_s.st = (frm.par != RDMH_PAR_NONE) ?
                                    R_PAR : R_STOP;
                    end
                end
                R_PAR: begin
                    next_s.perr = (rxd != rdmh_parity(word, frm));
                    next_s.st   = R_STOP;
                end
                R_STOP: begin
                    next_s.ferr  = !rxd;
                    next_s.data  = word;
                    next_s.valid = 1'b1;
                    next_s.st    = R_IDLE;
                end
                default: begin
                    next_s.st = R_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign valid = s.valid & ce;
    assign data  = s.data;
    assign perr  = s.perr;
    assign ferr  = s.ferr;
endmodule

// [rtl/rdmh_top.sv]
// Serial control port as terminal equipment, with modem
// handshake, option cycling, error word and interrupt.
// Assumes all pins synchronous to clk and a one-cycle register port.
//
// Functional notes
// - Serial port as terminal equipment, driving TX, DTR, RTS.
// - Nine bit rates, 50 to 9600; both ends match.
// - Parity none/even/odd/mark/space, one or two stops, 7 or 8 bits.
// - Modem handshake on/off; half or full duplex.
// - Software flow: on/off characters or none; enquiry/ack selectable but acts as none.
// - Outside lockout, each local select pulse steps its option on, wrapping.
// - Echo set remotely; status also read remotely.
// - Remote command sets local lockout; state is held.
// - No handshake: data lines only; both sides always accept.
// - No handshake: terminal ready and request to send held high.
// - No handshake: set ready, clear to send, carrier all ignored.
// - Full handshake uses DTR, DSR, RTS, CTS; carrier ignored.
// - Full handshake: DTR high once port is ready.
// - Full handshake: RTS raised only when DTR and DSR both true.
// - Full handshake: no transmit until modem answers RTS with CTS.
// - Error status word clears when read, but an error or local step in that cycle sets its bit.
`timescale 1ns/10ps
`include "rdmh_regs.svh"
module rdmh_top #(
    parameter int CLK_HZ = `RDMH_CLK_HZ  // Clock rate, shrink in simulation
) (
    input  wire logic                      clk,     // System clock
    input  wire logic                      ce,      // Clock enable
    input  wire logic                      sys_rst, // Sync reset, high
    input  wire logic [`RDMH_AW-1:0]       addr,    // Register byte address
    input  wire logic [31:0]               wdata,   // Write data
    input  wire logic                      wr,      // Write strobe
    input  wire logic                      rd,      // Read strobe
    output logic      [31:0]               rdata,   // Read data, next cycle
    input  wire logic [`RDMH_NSEL-1:0]     sel,     // Local option steps
    input  wire logic                      rxd,     // Received data
    input  wire rdmh_pkg::rdmh_modem_t     modem,   // CTS, DSR, DCD
    output logic                           txd,     // Transmitted data
    output logic                           rts,     // Request to send
    output logic                           dtr,     // Terminal ready
    output logic                           irq      // Interrupt, level
);
    import rdmh_pkg::*;

    typedef struct packed {
        rdmh_cfg_t               cfg;
        logic                    ready;
        logic [7:0]              tx_byte;
        logic                    tx_pend;
        logic [7:0]              rx_byte;
        logic                    rx_full;
        logic [`RDMH_ERR_W-1:0]  err;
        logic [2:0]              ist;
        logic [2:0]              imask;
        logic                    xoff;
        logic                    rts;
        logic [31:0]             rdata;
    } rdmh_st_t;

    rdmh_st_t s;
    rdmh_st_t next_s;

    logic [23:0] div;
    logic        tx_busy;
    logic        tx_go;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        rx_perr;
    logic        rx_ferr;
    logic        rx_take;
    logic        lines_ok;

    // Cycles per bit for a rate index
    function automatic logic [23:0] bit_div(logic [3:0] i);
        int r;
        case (i)
            4'h0:    r = 50;
            4'h1:    r = 75;
            4'h2:    r = 110;
            4'h3:    r = 150;
            4'h4:    r = 300;
            4'h5:    r = 600;
            4'h6:    r = 1200;
            4'h7:    r = 4800;
            default: r = 9600;
        endcase
        bit_div = 24'(CLK_HZ / r);
    endfunction

    // Step an option counter, wrapping at its count
    function automatic logic [3:0] step(logic [3:0] v, logic [3:0] n);
        step = (v + 4'h1 >= n) ? 4'h0 : v + 4'h1;
    endfunction

    assign div = bit_div(s.cfg.baud);

    // Line drivers: forced high without handshake
    assign dtr = s.cfg.hs_on ? s.ready : 1'b1;
    assign rts = s.cfg.hs_on ? s.rts : 1'b1;

    // Ready lines gate sending; carrier unused
    assign lines_ok = s.cfg.hs_on ? (s.rts & modem.cts) : 1'b1;

    // Hand the held character to the shifter
    assign tx_go = ce & s.tx_pend & ~tx_busy & ~s.xoff & lines_ok;

    // Half duplex with handshake: no receive while RTS is high
    assign rx_take = rx_valid &
                     ~(s.cfg.hs_on & ~s.cfg.full_dup & s.rts);

    always_comb begin
        next_s       = s;
        next_s.rdata = 32'h0;

        // RTS needs DTR and DSR, drops after sending
        next_s.rts = s.cfg.hs_on & s.ready & modem.dsr &
                     (s.tx_pend | tx_busy);

        if (tx_go) begin
            next_s.tx_pend = 1'b0;
        end

        // Register reads and read clears
        if (rd) begin
            case (addr)
                `RDMH_CFG:    next_s.rdata = 32'(s.cfg);
                `RDMH_CTRL:   next_s.rdata = 32'(s.ready);
                `RDMH_TXDATA: next_s.rdata = 32'(s.tx_byte);
                `RDMH_RXDATA: begin
                    next_s.rdata   = 32'(s.rx_byte);
                    next_s.rx_full = 1'b0;
                end
                `RDMH_ERR: begin
                    next_s.rdata = 32'(s.err);
                    next_s.err   = '0;
                end
                `RDMH_ISTAT: begin
                    next_s.rdata = 32'(s.ist);
                    next_s.ist   = 3'h0;
                end
                `RDMH_IMASK:  next_s.rdata = 32'(s.imask);
                `RDMH_LINE:   next_s.rdata = 32'({s.xoff, tx_busy,
                                  s.tx_pend, s.rx_full, modem.dcd,
                                  modem.cts, modem.dsr, rts, dtr});
                default:      next_s.rdata = 32'h0;
            endcase
        end

        // Local steps, refused under lockout
        if (!s.cfg.lockout && |sel) begin
            next_s.err[`RDMH_ERR_FRONT] = 1'b1;
            if (sel[0]) begin
                next_s.cfg.baud = step(s.cfg.baud, 4'(`RDMH_NBAUD));
            end
            if (sel[1]) begin
                next_s.cfg.full_dup = ~s.cfg.full_dup;
            end
            if (sel[2]) begin
                next_s.cfg.hs_on = ~s.cfg.hs_on;
            end
            if (sel[3]) begin
                next_s.cfg.swfc = rdmh_sw_t'(2'(step(4'(s.cfg.swfc),
                                                     4'h3)));
            end
            if (sel[4]) begin
                next_s.cfg.frm.par = rdmh_par_t'(3'(step(
                                     4'(s.cfg.frm.par), 4'h5)));
            end
            if (sel[5]) begin
                next_s.cfg.frm.stop2 = ~s.cfg.frm.stop2;
            end
            if (sel[6]) begin
                next_s.cfg.frm.len8 = ~s.cfg.frm.len8;
            end
        end

        // Echo in full duplex
        if (rx_take && s.cfg.echo && s.cfg.full_dup &&
            (!s.tx_pend || tx_go)) begin
            next_s.tx_byte = rx_data;
            next_s.tx_pend = 1'b1;
        end

        // Register writes win over local steps
        if (wr) begin
            case (addr)
                `RDMH_CFG:    next_s.cfg = rdmh_cfg_t'(
                                  wdata[`RDMH_CFG_W-1:0]);
                `RDMH_CTRL:   next_s.ready = wdata[0];
                `RDMH_TXDATA: begin
                    next_s.tx_byte = wdata[7:0];
                    next_s.tx_pend = 1'b1;
                end
                `RDMH_IMASK:  next_s.imask = wdata[2:0];
                default:      next_s.imask = next_s.imask;
            endcase
        end

        // Events set after any clear, so they win
        if (rx_take) begin
            next_s.rx_byte = rx_data;
            next_s.rx_full = 1'b1;
            next_s.ist[`RDMH_INT_RX] = 1'b1;
            if (s.rx_full && !(rd && addr == `RDMH_RXDATA)) begin
                next_s.err[`RDMH_ERR_OVR] = 1'b1;
            end
            if (rx_perr) begin
                next_s.err[`RDMH_ERR_PAR] = 1'b1;
            end
            if (rx_ferr) begin
                next_s.err[`RDMH_ERR_FRM] = 1'b1;
            end
            // Flow characters pause or resume sending
            if (s.cfg.swfc == RDMH_SW_XONOFF) begin
                if (rx_data == `RDMH_CH_XOFF) begin
                    next_s.xoff = 1'b1;
                end else if (rx_data == `RDMH_CH_XON) begin
                    next_s.xoff = 1'b0;
                end
            end
        end
        if (s.cfg.swfc != RDMH_SW_XONOFF) begin
            next_s.xoff = 1'b0;
        end
        if (tx_go) begin
            next_s.ist[`RDMH_INT_TX] = 1'b1;
        end
        if (next_s.err[`RDMH_ERR_FRM:`RDMH_ERR_OVR] != 3'h0 &&
            s.err[`RDMH_ERR_FRM:`RDMH_ERR_OVR] !=
            next_s.err[`RDMH_ERR_FRM:`RDMH_ERR_OVR]) begin
            next_s.ist[`RDMH_INT_ERR] = 1'b1;
        end
    end

    // State frozen while enable is low
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s       <= '0;
            s.cfg   <= rdmh_cfg_t'(`RDMH_CFG_RST);
            s.ready <= `RDMH_CTRL_RST;
        end else if (ce) begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign irq   = |(s.ist & s.imask);

    rdmh_tx u_tx (
        .clk     (clk),
        .ce      (ce),
        .sys_rst (sys_rst),
        .div     (div),
        .frm     (s.cfg.frm),
        .go      (tx_go),
        .data    (s.tx_byte),
        .txd     (txd),
        .busy    (tx_busy)
    );

    // Receiver always listens; carrier plays no part
    rdmh_rx u_rx (
        .clk     (clk),
        .ce      (ce),
        .sys_rst (sys_rst),
        .div     (div),
        .frm     (s.cfg.frm),
        .rxd     (rxd),
        .valid   (rx_valid),
        .data    (rx_data),
        .perr    (rx_perr),
        .ferr    (rx_ferr)
    );
endmodule

// [sim/rdmh_properties.sv]
// Checker of the port pins and register bus.
// Assumes it is bound onto rdmh_top.
`timescale 1ns/10ps
module rdmh_properties #(
    parameter int CLK_HZ = 50000000 // Bit-time base
) (
    input wire logic                  clk,     // Clock
    input wire logic                  ce,      // Enable
    input wire logic                  sys_rst, // Reset
    input wire logic [7:0]            addr,    // Address
    input wire logic [31:0]           wdata,   // Write data
    input wire logic                  wr,      // Write
    input wire logic                  rd,      // Read
    input wire logic [31:0]           rdata,   // Read data
    input wire logic [6:0]            sel,     // Steps
    input wire rdmh_pkg::rdmh_modem_t modem,   // Modem lines
    input wire logic                  txd,     // Serial out
    input wire logic                  rts,     // Request
    input wire logic                  dtr,     // Ready
    input wire logic                  irq      // Interrupt
);
    logic hs, lk, rdy, st_rd, mk_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Settings mirror; writes beat steps
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hs  <= 1'b0;
            lk  <= 1'b0;
            rdy <= 1'b1;
        end else if (ce) begin
            if (wr && addr == 8'h00) begin
                hs <= wdata[9];
                lk <= wdata[14];
            end else if (sel[2] && !lk) begin
                hs <= ~hs;
            end
            if (wr && addr == 8'h04) begin
                rdy <= wdata[0];
            end
        end
    end
    // Accesses that may lower irq
    assign st_rd = ce && rd && addr == 8'h14;
    assign mk_wr = ce && wr && addr == 8'h18;
    a_nohs_lines: assert property (!hs |-> dtr && rts)
        else $error("dtr or rts low with handshake off");
    a_hs_ready: assert property (hs |-> dtr == rdy)
        else $error("dtr does not follow ready");
    a_rts_rise: assert property (hs && $past(hs) && $rose(rts) |->
        $past(modem.dsr) && $past(dtr))
        else $error("rts rose without dsr and dtr");
    a_dsr_low: assert property (hs && $past(hs) &&
        !$past(modem.dsr) |-> !rts)
        else $error("rts high while dsr low");
    a_norts_idle: assert property (hs && $past(hs) &&
        !rts && !$past(rts) |-> txd)
        else $error("txd active without request");
    a_reset_idle: assert property ($past(sys_rst) |->
        txd && rdata == 32'h0 && !irq)
        else $error("outputs not idle after reset");
    a_rdata_quiet: assert property ($past(ce) && !$past(rd) |->
        rdata == 32'h0)
        else $error("rdata nonzero without a read");
    a_irq_fall: assert property ($fell(irq) |->
        $past(st_rd) || $past(mk_wr))
        else $error("irq fell with no clear");
    c_rts_up: cover property (hs && $rose(rts));
    c_tx_go: cover property (hs && $fell(txd));
    c_irq_up: cover property ($rose(irq));
endmodule

bind rdmh_top rdmh_properties #(.CLK_HZ(CLK_HZ)) u_props (
    .clk(clk), .ce(ce), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sel(sel), .modem(modem),
    .txd(txd), .rts(rts), .dtr(dtr), .irq(irq)
);

// [sim/rdmh_modem_model.sv]
// Far-end terminal and modem.
// Assumes BIT clocks per bit.
`timescale 1ns/10ps
module rdmh_modem_model #(
    parameter int BIT = 10 // Same rate at both ends
) (
    input wire logic              clk,    // Clock
    input wire logic              txd,    // Port serial out
    input wire logic              rts,    // Port request
    input wire logic              dsr_on, // Modem ready
    input wire logic              cts_on, // Line able to carry
    output logic                  rxd,    // Serial to port
    output rdmh_pkg::rdmh_modem_t modem   // CTS, DSR, DCD
);
    import rdmh_pkg::*;
    logic [8:0] got;
    int         rx_count;
    // Clear answers a request; carrier churns, ignored
    always @(posedge clk) begin
        modem.dsr <= dsr_on;
        modem.cts <= cts_on && rts;
        modem.dcd <= ~rxd;
    end
    // Capture 8 data bits plus parity or stop
    initial begin
        rx_count = 0;
        rxd = 1'b1;
        forever begin
            @(negedge txd);
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT) @(posedge clk);
                got[i] = txd;
            end
            wait (txd === 1'b1);
            rx_count++;
        end
    end
    // Short frames only, no flow control
    task automatic send(input logic [9:0] bits, input int n);
        rxd <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat (BIT) @(posedge clk);
        end
        rxd <= 1'b1;
        repeat (2 * BIT) @(posedge clk);
    endtask
endmodule

// [sim/rdmh_top_tb.sv]
// Bench: register tasks and far-end model.
// Assumes 9600 baud is ten clocks per bit.
`timescale 1ns/10ps
`include "rdmh_regs.svh"
module rdmh_top_tb;
    import rdmh_pkg::*;
    logic        clk, rxd, txd, rts, dtr, irq;
    logic        ce = 1'b1, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        dsr_on = 1'b0, cts_on = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [6:0]  sel = 7'h00;
    rdmh_modem_t modem;
    int          fail_count = 0, n_checks = 0, c0;
    logic [4:0]  pbit = 5'b01011;
    logic [15:0] steps [7] = '{16'h0500, 16'h0100, 16'h0300, 16'h0B00,
                               16'h0B10, 16'h0B90, 16'h0A90};
    rdmh_top #(.CLK_HZ(96000)) u_dut (
        .clk(clk), .ce(ce), .sys_rst(sys_rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sel(sel),
        .rxd(rxd), .modem(modem), .txd(txd), .rts(rts), .dtr(dtr),
        .irq(irq)
    );
    rdmh_modem_model #(.BIT(10)) u_far (
        .clk(clk), .txd(txd), .rts(rts), .dsr_on(dsr_on),
        .cts_on(cts_on), .rxd(rxd), .modem(modem)
    );
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        check(rdata, e);
    endtask
    // Pins looked at mid-cycle
    task automatic pin(input logic v, input logic e);
        @(negedge clk);
        check({31'h0, v}, {31'h0, e});
        @(posedge clk);
    endtask
    // Settle past the stop bit
    task automatic wait_char(input logic [8:0] e);
        for (int i = 0; i < 400 && u_far.rx_count == c0; i++) @(posedge clk);
        repeat (20) @(posedge clk);
        check({23'h0, u_far.got}, {23'h0, e});
    endtask
    task automatic complete_run();
        if (fail_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        pin(dtr && rts, 1'b1);
        expect_reg(`RDMH_CFG, 32'h0508);
        // Local steps, wrapping
        for (int k = 0; k < 7; k++) begin
            sel <= 7'h01 << k;
            @(posedge clk);
            sel <= 7'h00;
            expect_reg(`RDMH_CFG, {16'h0, steps[k]});
        end
        expect_reg(`RDMH_ERR, 32'h08);
        expect_reg(`RDMH_ERR, 32'h00);
        wr_reg(`RDMH_CFG, 32'h4508);
        sel <= 7'h01;
        @(posedge clk);
        sel <= 7'h00;
        expect_reg(`RDMH_CFG, 32'h4508);
        expect_reg(`RDMH_ERR, 32'h00);
        // Every parity, modem lines false
        for (int p = 0; p < 5; p++) begin
            wr_reg(`RDMH_CFG, 32'h0508 | (p << 4));
            c0 = u_far.rx_count;
            wr_reg(`RDMH_TXDATA, 32'hA7);
            wait_char({pbit[p], 8'hA7});
        end
        // Full handshake
        wr_reg(`RDMH_CFG, 32'h0708);
        wr_reg(`RDMH_CTRL, 32'h0);
        pin(dtr, 1'b0);
        wr_reg(`RDMH_CTRL, 32'h1);
        pin(dtr, 1'b1);
        cts_on <= 1'b1;
        c0 = u_far.rx_count;
        wr_reg(`RDMH_TXDATA, 32'h3C);
        repeat (40) @(posedge clk);
        pin(rts, 1'b0);
        dsr_on <= 1'b1;
        cts_on <= 1'b0;
        repeat (40) @(posedge clk);
        pin(rts, 1'b1);
        check(u_far.rx_count - c0, 32'h0);
        cts_on <= 1'b1;
        wait_char(9'h13C);
        // Even-parity receive, errors, interrupt
        wr_reg(`RDMH_CFG, 32'h0518);
        wr_reg(`RDMH_IMASK, 32'h1);
        expect_reg(`RDMH_ISTAT, 32'h2);
        u_far.send(10'h05A, 9);
        pin(irq, 1'b1);
        expect_reg(`RDMH_ISTAT, 32'h1);
        pin(irq, 1'b0);
        expect_reg(`RDMH_RXDATA, 32'h5A);
        u_far.send(10'h15A, 9);
        u_far.send(10'h05A, 10);
        // A low stop may fake a start
        repeat (150) @(posedge clk);
        expect_reg(`RDMH_ERR, 32'h70);
        expect_reg(`RDMH_ERR, 32'h00);
        pin(irq, 1'b1);
        wr_reg(`RDMH_IMASK, 32'h0);
        pin(irq, 1'b0);
        expect_reg(`RDMH_ISTAT, 32'h5);
        complete_run();
    end
endmodule
